// File: src/tpw_defs.svh
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH

// Register offsets (word index on the plain register port)
`define TPW_OFF_COUNTER 4'h0
`define TPW_OFF_PERIOD 4'h1
`define TPW_OFF_CHANGE 4'h2
`define TPW_OFF_WAIT 4'h3
`define TPW_OFF_BUFFER 4'h4
`define TPW_OFF_MODE 4'h5
`define TPW_OFF_CTRL1 4'h6
`define TPW_OFF_CTRL2 4'h7
`define TPW_OFF_STATUS 4'h8
`define TPW_OFF_IRQ_EN 4'h9
`define TPW_OFF_IRQ_CTRL 4'ha

// Mode register fields
`define TPW_MODE_RUN_BIT 0
`define TPW_MODE_BUFC_BIT 1
`define TPW_MODE_BUFD_BIT 2
// Control one fields
`define TPW_CR1_INIT_BIT 0
`define TPW_CR1_CLR_BIT 1
`define TPW_CR1_SRC_LSB 2
`define TPW_CR1_SRC_MSB 4
// Control two fields
`define TPW_CR2_STOP_BIT 0
`define TPW_CR2_EDGE_LSB 1
`define TPW_CR2_EDGE_MSB 2
// Status / enable fields: A, B, C, D match, overflow
`define TPW_ST_MATCH_A 0
`define TPW_ST_MATCH_B 1
`define TPW_ST_MATCH_C 2
`define TPW_ST_MATCH_D 3
`define TPW_ST_OVF 4
`define TPW_NUM_SRC 5
// Interrupt control fields
`define TPW_IC_LVL_LSB 0
`define TPW_IC_LVL_MSB 2
`define TPW_IC_REQ_BIT 3

// Reset values
`define TPW_RST_COMPARE 16'hffff
`define TPW_RST_BYTE 8'h00

`endif

// File: src/tpw_pkg.sv
`default_nettype none
package tpw_pkg;
   // Register port request, bundled
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tpw_bus_req_t;

   // Capture inputs, one bit per compare register
   typedef struct packed {
      logic [3:0] level;
   } tpw_cap_t;

   // Gray-coded waveform phases
   typedef enum logic [1:0] {
      TPW_IDLE = 2'b00,
      TPW_WAIT = 2'b01,
      TPW_ACTIVE = 2'b11,
      TPW_TAIL = 2'b10
   } tpw_phase_t;
endpackage
`default_nettype wire

// File: src/tpw_source_div.sv
`timescale 1ns/1ps
`default_nettype none
// Count-source divider: a one-cycle enable at 1/2^sel of the clock
module tpw_source_div #(
   parameter int WIDTH = 7
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [2:0] sel_i,
   output logic tick_o
);
   logic [WIDTH-1:0] div_cnt;
   logic [WIDTH-1:0] next_div_cnt;
   logic next_tick;

   // Free-running prescaler; tick when the selected low bits all ones
   always_comb
   begin
      next_div_cnt = div_cnt + {{(WIDTH-1){1'b0}}, 1'b1};
      next_tick = 1'b1;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (i < int'(sel_i) && !div_cnt[i])
         begin
            next_tick = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         div_cnt <= '0;
         tick_o <= 1'b0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         tick_o <= next_tick;
      end
   end
endmodule // tpw_source_div
`default_nettype wire

// File: src/tpw_capture_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Capture edge detector: one stage delay, then edge compare (two cycles)
module tpw_capture_sync #(
   parameter int NCH = 4
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [NCH-1:0] pin_i,
   output logic [NCH-1:0] edge_o
);
   logic [NCH-1:0] stage;
   logic [NCH-1:0] prev;

   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         // Rising edge per channel; pins are taken as synchronous
         always_ff @(posedge ref_clk_i)
         begin
            if (!rst_b_i)
            begin
               stage[g] <= 1'b0;
               prev[g] <= 1'b0;
               edge_o[g] <= 1'b0;
            end
            else
            begin
               stage[g] <= pin_i[g];
               prev[g] <= stage[g];
               edge_o[g] <= stage[g] & ~prev[g];
            end
         end
      end
   endgenerate
endmodule // tpw_capture_sync
`default_nettype wire

// File: src/tpw_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.svh"
module tpw_timer #(
   parameter int CW = 16
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire tpw_pkg::tpw_bus_req_t bus_i,
   output logic [15:0] rdata_o,
   input wire logic trigger_pin_i,
   input wire tpw_pkg::tpw_cap_t capture_pin_i,
   output logic pwm_out_pin_o,
   output logic request_pending_o,
   output logic [2:0] priority_level_o
);
   import tpw_pkg::*;

   logic [CW-1:0] main_counter;
   logic [CW-1:0] cmp [4];
   logic [7:0] timer_mode_reg;
   logic [7:0] control_one_reg;
   logic [7:0] control_two_reg;
   logic [4:0] status_flags_reg;
   logic [4:0] irq_enable_reg;
   logic [2:0] priority_level;
   tpw_phase_t phase;
   logic trig_prev;

   logic [CW-1:0] next_main_counter;
   logic [CW-1:0] next_cmp [4];
   logic [7:0] next_timer_mode_reg;
   logic [7:0] next_control_one_reg;
   logic [7:0] next_control_two_reg;
   logic [4:0] next_status;
   logic [4:0] next_irq_enable;
   logic [2:0] next_priority_level;
   tpw_phase_t next_phase;
   logic next_pwm;
   logic next_req;
   logic [15:0] next_rdata;

   logic tick;
   logic [3:0] cap_edge;
   logic count_run;
   logic buffer_c_select;
   logic buffer_d_select;
   logic init_level;
   logic clear_on_match;
   logic stop_on_period_match;
   logic [1:0] trig_edge_sel;
   logic trig_fire;
   logic [4:0] events;
   logic wr_hit;

   assign count_run = timer_mode_reg[`TPW_MODE_RUN_BIT];
   assign buffer_c_select = timer_mode_reg[`TPW_MODE_BUFC_BIT];
   assign buffer_d_select = timer_mode_reg[`TPW_MODE_BUFD_BIT];
   assign init_level = control_one_reg[`TPW_CR1_INIT_BIT];
   assign clear_on_match = control_one_reg[`TPW_CR1_CLR_BIT];
   assign stop_on_period_match = control_two_reg[`TPW_CR2_STOP_BIT];
   assign trig_edge_sel = control_two_reg[`TPW_CR2_EDGE_MSB:`TPW_CR2_EDGE_LSB];

   // Count source, selected by the three source_select bits
   tpw_source_div #(
      .WIDTH(7)
   ) u_div (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .sel_i(control_one_reg[`TPW_CR1_SRC_MSB:`TPW_CR1_SRC_LSB]),
      .tick_o(tick)
   );

   // Capture edges land two cycles after the pin rises
   tpw_capture_sync #(
      .NCH(4)
   ) u_cap (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(capture_pin_i.level),
      .edge_o(cap_edge)
   );

   // Trigger edge select: 01 rising, 10 falling, 11 both, 00 off
   always_comb
   begin
      case (trig_edge_sel)
         2'b01: trig_fire = trigger_pin_i & ~trig_prev;
         2'b10: trig_fire = ~trigger_pin_i & trig_prev;
         2'b11: trig_fire = trigger_pin_i ^ trig_prev;
         default: trig_fire = 1'b0;
      endcase
   end

   // Counter, compare registers, waveform and flags
   always_comb
   begin
      next_main_counter = main_counter;
      for (int k = 0; k < 4; k++)
      begin
         next_cmp[k] = cmp[k];
      end
      next_timer_mode_reg = timer_mode_reg;
      next_control_one_reg = control_one_reg;
      next_control_two_reg = control_two_reg;
      next_irq_enable = irq_enable_reg;
      next_priority_level = priority_level;
      next_phase = phase;
      next_pwm = pwm_out_pin_o;
      events = 5'h00;
      wr_hit = bus_i.wr;

      // Capture overrides compare contents when a pin edge arrives
      for (int k = 0; k < 4; k++)
      begin
         if (cap_edge[k])
         begin
            next_cmp[k] = main_counter;
         end
      end

      // A trigger restarts the wait phase
      if (count_run && trig_fire)
      begin
         next_main_counter = '0;
         next_phase = TPW_WAIT;
         next_pwm = init_level;
      end
      else if (count_run && tick)
      begin
         next_main_counter = main_counter + {{(CW-1){1'b0}}, 1'b1};
         if (main_counter == {CW{1'b1}})
         begin
            events[`TPW_ST_OVF] = 1'b1;
         end
         // Wait point ends the trigger wait: p+1 clocks
         if (!buffer_c_select && main_counter == cmp[2])
         begin
            events[`TPW_ST_MATCH_C] = 1'b1;
            next_pwm = ~init_level;
            next_phase = TPW_ACTIVE;
         end
         // Change point ends the active width: n-p clocks
         if (main_counter == cmp[1])
         begin
            events[`TPW_ST_MATCH_B] = 1'b1;
            next_pwm = init_level;
            next_phase = TPW_TAIL;
         end
         if (main_counter == cmp[3])
         begin
            events[`TPW_ST_MATCH_D] = 1'b1;
         end
         // Period end: m+1 clocks
         if (main_counter == cmp[0])
         begin
            events[`TPW_ST_MATCH_A] = 1'b1;
            next_pwm = init_level;
            if (buffer_d_select)
            begin
               next_cmp[1] = cmp[3];
            end
            if (clear_on_match)
            begin
               next_main_counter = '0;
            end
            if (stop_on_period_match)
            begin
               next_timer_mode_reg[`TPW_MODE_RUN_BIT] = 1'b0;
               next_phase = TPW_IDLE;
            end
            else
            begin
               next_phase = TPW_WAIT;
            end
         end
      end

      // Register writes; a counter write loses to the automatic clear
      if (wr_hit)
      begin
         case (bus_i.addr)
            `TPW_OFF_COUNTER:
            begin
               if (!(count_run && tick && clear_on_match && main_counter == cmp[0]))
               begin
                  next_main_counter = bus_i.wdata[CW-1:0];
               end
            end
            `TPW_OFF_PERIOD: next_cmp[0] = bus_i.wdata[CW-1:0];
            `TPW_OFF_CHANGE: next_cmp[1] = bus_i.wdata[CW-1:0];
            `TPW_OFF_WAIT: next_cmp[2] = bus_i.wdata[CW-1:0];
            `TPW_OFF_BUFFER: next_cmp[3] = bus_i.wdata[CW-1:0];
            `TPW_OFF_MODE: next_timer_mode_reg = bus_i.wdata[7:0];
            `TPW_OFF_CTRL1:
            begin
               next_control_one_reg = bus_i.wdata[7:0];
               next_pwm = bus_i.wdata[`TPW_CR1_INIT_BIT];
            end
            `TPW_OFF_CTRL2: next_control_two_reg = bus_i.wdata[7:0];
            `TPW_OFF_IRQ_EN: next_irq_enable = bus_i.wdata[4:0];
            `TPW_OFF_IRQ_CTRL:
               next_priority_level = bus_i.wdata[`TPW_IC_LVL_MSB:`TPW_IC_LVL_LSB];
            default: ;
         endcase
      end

      // Flags: software clears with zeros, a new event wins the same cycle
      next_status = status_flags_reg;
      if (wr_hit && bus_i.addr == `TPW_OFF_STATUS)
      begin
         next_status = status_flags_reg & bus_i.wdata[4:0];
      end
      next_status = next_status | events;

      // Combined request, recomputed every cycle and never latched
      next_req = |(next_status & next_irq_enable);
   end

   // Read mux; the value shown is the state before any write this cycle
   always_comb
   begin
      next_rdata = 16'h0000;
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            `TPW_OFF_COUNTER: next_rdata = 16'(main_counter);
            `TPW_OFF_PERIOD: next_rdata = 16'(cmp[0]);
            `TPW_OFF_CHANGE: next_rdata = 16'(cmp[1]);
            `TPW_OFF_WAIT: next_rdata = 16'(cmp[2]);
            `TPW_OFF_BUFFER: next_rdata = 16'(cmp[3]);
            `TPW_OFF_MODE: next_rdata = {8'h00, timer_mode_reg};
            `TPW_OFF_CTRL1: next_rdata = {8'h00, control_one_reg};
            `TPW_OFF_CTRL2: next_rdata = {8'h00, control_two_reg};
            `TPW_OFF_STATUS: next_rdata = {11'h000, status_flags_reg};
            `TPW_OFF_IRQ_EN: next_rdata = {11'h000, irq_enable_reg};
            `TPW_OFF_IRQ_CTRL: next_rdata = {12'h000, request_pending_o, priority_level};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         main_counter <= '0;
         for (int k = 0; k < 4; k++)
         begin
            cmp[k] <= CW'(`TPW_RST_COMPARE);
         end
         timer_mode_reg <= `TPW_RST_BYTE;
         control_one_reg <= `TPW_RST_BYTE;
         control_two_reg <= `TPW_RST_BYTE;
         status_flags_reg <= 5'h00;
         irq_enable_reg <= 5'h00;
         priority_level <= 3'h0;
         phase <= TPW_IDLE;
         trig_prev <= 1'b0;
         pwm_out_pin_o <= 1'b0;
         request_pending_o <= 1'b0;
         priority_level_o <= 3'h0;
         rdata_o <= 16'h0000;
      end
      else
      begin
         main_counter <= next_main_counter;
         for (int k = 0; k < 4; k++)
         begin
            cmp[k] <= next_cmp[k];
         end
         timer_mode_reg <= next_timer_mode_reg;
         control_one_reg <= next_control_one_reg;
         control_two_reg <= next_control_two_reg;
         status_flags_reg <= next_status;
         irq_enable_reg <= next_irq_enable;
         priority_level <= next_priority_level;
         phase <= next_phase;
         trig_prev <= trigger_pin_i;
         pwm_out_pin_o <= next_pwm;
         request_pending_o <= next_req;
         priority_level_o <= next_priority_level;
         rdata_o <= next_rdata;
      end
   end
endmodule // tpw_timer
`default_nettype wire

// File: testbench/tpw_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side pin sources: capture levels and trigger, idle low between pulses
module tpw_partner (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [4:0] fire_i,
   output var tpw_pkg::tpw_cap_t capture_pin_o,
   output logic trigger_pin_o
);
   import tpw_pkg::*;
   logic [4:0] lvl;
   logic [1:0] hold;
   // Each pulse stands three clocks, never shorter
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         lvl <= 5'h00;
         hold <= 2'h0;
      end
      else if (fire_i != 5'h00)
      begin
         lvl <= fire_i;
         hold <= 2'h2;
      end
      else if (hold != 2'h0)
         hold <= hold - 2'h1;
      else
         lvl <= 5'h00;
   end
   assign capture_pin_o.level = lvl[3:0];
   assign trigger_pin_o = lvl[4];
endmodule // tpw_partner
`default_nettype wire

// File: testbench/tpw_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.svh"
// Port-level checks on read data, priority level and merged request
module tpw_timer_sva #(
   parameter int CW = 16
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire tpw_pkg::tpw_bus_req_t bus_i,
   input wire logic [15:0] rdata_o,
   input wire logic trigger_pin_i,
   input wire tpw_pkg::tpw_cap_t capture_pin_i,
   input wire logic pwm_out_pin_o,
   input wire logic request_pending_o,
   input wire logic [2:0] priority_level_o
);
   import tpw_pkg::*;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Writes and reads of interest
   sequence s_en_off;
      bus_i.wr && bus_i.addr == `TPW_OFF_IRQ_EN && bus_i.wdata[4:0] == 5'h00;
   endsequence
   sequence s_lvl_wr;
      bus_i.wr && bus_i.addr == `TPW_OFF_IRQ_CTRL;
   endsequence
   sequence s_ic_rd;
      bus_i.rd && bus_i.addr == `TPW_OFF_IRQ_CTRL;
   endsequence
   chk_reset_outputs: assert property (disable iff (1'b0) !rst_b_i |=>
      !pwm_out_pin_o && !request_pending_o && rdata_o == 16'h0000)
      else $error("outputs not cleared by reset");
   chk_read_idle: assert property (!bus_i.rd |=> rdata_o == 16'h0000)
      else $error("read data outside read slot");
   chk_unmapped_read: assert property (bus_i.rd && bus_i.addr > `TPW_OFF_IRQ_CTRL
      |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   chk_level_follow: assert property (
      s_lvl_wr |=> priority_level_o == $past(bus_i.wdata[2:0]))
      else $error("priority level not taken");
   chk_level_hold: assert property (
      $changed(priority_level_o) && $past(rst_b_i) |->
      $past(bus_i.wr) && $past(bus_i.addr) == `TPW_OFF_IRQ_CTRL)
      else $error("priority level changed unasked");
   chk_req_drop: assert property (s_en_off |=> ##1 !request_pending_o)
      else $error("request kept with no enable");
   // The request register drops at the write edge, so the cause is one sample back
   chk_fall_cause: assert property (
      $fell(request_pending_o) && $past(rst_b_i) |-> $past(bus_i.wr) &&
      ($past(bus_i.addr) == `TPW_OFF_STATUS || $past(bus_i.addr) == `TPW_OFF_IRQ_EN))
      else $error("request fell without software write");
   chk_read_mirror: assert property (
      s_ic_rd |=> rdata_o[3] == $past(request_pending_o) &&
      rdata_o[2:0] == $past(priority_level_o))
      else $error("control read disagrees with outputs");
   cov_capture: cover property (capture_pin_i.level != 4'h0 && !trigger_pin_i);
endmodule // tpw_timer_sva
bind tpw_timer tpw_timer_sva #(.CW(CW)) u_sva (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
   .bus_i(bus_i), .rdata_o(rdata_o), .trigger_pin_i(trigger_pin_i),
   .capture_pin_i(capture_pin_i), .pwm_out_pin_o(pwm_out_pin_o),
   .request_pending_o(request_pending_o), .priority_level_o(priority_level_o));
`default_nettype wire

// File: testbench/tpw_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defs.svh"
// Self-checking bench for the PWM timer and its merged request
module tpw_timer_tb_top;
   import tpw_pkg::*;
   logic ref_clk_i;
   logic rst_b_i;
   tpw_bus_req_t bus;
   logic [15:0] rdata;
   logic trig;
   tpw_cap_t cap;
   logic pwm;
   logic req;
   logic [2:0] lvl;
   logic [4:0] fire;
   logic [15:0] d;
   int mismatches;
   int check_count;

   tpw_timer #(.CW(16)) dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_i(bus),
      .rdata_o(rdata), .trigger_pin_i(trig), .capture_pin_i(cap), .pwm_out_pin_o(pwm),
      .request_pending_o(req), .priority_level_o(lvl));
   tpw_partner u_partner (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .fire_i(fire),
      .capture_pin_o(cap), .trigger_pin_o(trig));

   // 40 MHz clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   task summarize;
      if (mismatches == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Settle one ns past the edge so registered outputs have landed
   task cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask

   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge ref_clk_i);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= v;
      @(posedge ref_clk_i);
      bus.wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge ref_clk_i);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge ref_clk_i);
      bus.rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task rd_chk(input logic [3:0] a, input logic [15:0] e);
      rd(a, d);
      check(d, e);
   endtask

   // Bounded wait for a pin level, counting cycles
   task wait_pwm(input logic v, output int n);
      n = 0;
      while (pwm !== v)
      begin
         cyc(1);
         n++;
         if (n > 200)
         begin
            mismatches++;
            $display("[ERR] %0t pwm wait ran out", $time);
            summarize;
         end
      end
   endtask

   // Reset values, with one unmapped word at the end
   task t_reset;
      for (int a = 0; a < 12; a++)
         rd_chk(4'(a), (a >= 1 && a <= 4) ? 16'hffff : 16'h0000);
   endtask

   // Initial level on control write, then period and active width
   task t_pwm;
      int hi;
      int lo;
      int n;
      wr(`TPW_OFF_PERIOD, 16'h0013);
      wr(`TPW_OFF_CHANGE, 16'h000c);
      wr(`TPW_OFF_WAIT, 16'h0004);
      wr(`TPW_OFF_CTRL1, 16'h0003);
      cyc(2);
      check({15'h0000, pwm}, 16'h0001);
      wr(`TPW_OFF_CTRL1, 16'h0002);
      cyc(2);
      check({15'h0000, pwm}, 16'h0000);
      wr(`TPW_OFF_MODE, 16'h0001);
      wait_pwm(1'b1, n);
      wait_pwm(1'b0, hi);
      wait_pwm(1'b1, lo);
      check(16'(hi), 16'h0008);
      check(16'(hi + lo), 16'h0014);
   endtask

   // Stop on period match clears and parks the count at initial level
   task t_stop;
      wr(`TPW_OFF_MODE, 16'h0000);
      wr(`TPW_OFF_CTRL2, 16'h0001);
      wr(`TPW_OFF_PERIOD, 16'h0009);
      wr(`TPW_OFF_COUNTER, 16'h0000);
      wr(`TPW_OFF_MODE, 16'h0001);
      cyc(40);
      rd_chk(`TPW_OFF_COUNTER, 16'h0000);
      check({15'h0000, pwm}, 16'h0000);
      cyc(5);
      rd_chk(`TPW_OFF_COUNTER, 16'h0000);
   endtask

   // Merged request: masked, raised, widened, held, masked, cleared
   task t_irq;
      check({15'h0000, req}, 16'h0000);
      wr(`TPW_OFF_IRQ_EN, 16'h0001);
      cyc(2);
      check({15'h0000, req}, 16'h0001);
      rd(`TPW_OFF_STATUS, d);
      check({15'h0000, d[`TPW_ST_MATCH_A]}, 16'h0001);
      wr(`TPW_OFF_IRQ_EN, 16'h0005);
      wr(`TPW_OFF_IRQ_CTRL, 16'h0005);
      cyc(10);
      check({15'h0000, req}, 16'h0001);
      check({13'h0000, lvl}, 16'h0005);
      rd_chk(`TPW_OFF_IRQ_CTRL, 16'h000d);
      wr(`TPW_OFF_IRQ_EN, 16'h0000);
      cyc(2);
      check({15'h0000, req}, 16'h0000);
      wr(`TPW_OFF_IRQ_EN, 16'h0005);
      cyc(2);
      check({15'h0000, req}, 16'h0001);
      wr(`TPW_OFF_STATUS, 16'h0000);
      cyc(2);
      check({15'h0000, req}, 16'h0000);
      rd_chk(`TPW_OFF_STATUS, 16'h0000);
   endtask

   // Capture into each compare register while the count is parked
   task t_cap;
      wr(`TPW_OFF_MODE, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         wr(`TPW_OFF_COUNTER, 16'h0100 + 16'(i));
         rd_chk(`TPW_OFF_COUNTER, 16'h0100 + 16'(i));
         @(posedge ref_clk_i);
         fire <= 5'(1 << i);
         @(posedge ref_clk_i);
         fire <= 5'h00;
         cyc(4);
         rd_chk(4'(1 + i), 16'h0100 + 16'(i));
      end
   endtask

   // Halved count source and buffer D: widths double, then the buffered point applies
   task t_src;
      int hi;
      int lo;
      int hi2;
      int n;
      wr(`TPW_OFF_CTRL2, 16'h0000);
      wr(`TPW_OFF_PERIOD, 16'h0013);
      wr(`TPW_OFF_CHANGE, 16'h000c);
      wr(`TPW_OFF_WAIT, 16'h0004);
      wr(`TPW_OFF_BUFFER, 16'h0008);
      wr(`TPW_OFF_COUNTER, 16'h0000);
      wr(`TPW_OFF_CTRL1, 16'h0006);
      cyc(2);
      wr(`TPW_OFF_MODE, 16'h0005);
      wait_pwm(1'b1, n);
      wait_pwm(1'b0, hi);
      wait_pwm(1'b1, lo);
      wait_pwm(1'b0, hi2);
      check(16'(hi), 16'h0010);
      check(16'(hi + lo), 16'h0028);
      check(16'(hi2), 16'h0008);
   endtask

   // Trigger edges restart the count; a counter write on the clearing match is lost
   task t_trig;
      wr(`TPW_OFF_MODE, 16'h0000);
      wr(`TPW_OFF_CTRL1, 16'h0002);
      wr(`TPW_OFF_MODE, 16'h0001);
      for (int e = 1; e < 4; e++)
      begin
         wr(`TPW_OFF_COUNTER, 16'h0100);
         wr(`TPW_OFF_CTRL2, 16'(e << 1));
         @(posedge ref_clk_i);
         fire <= 5'h10;
         @(posedge ref_clk_i);
         fire <= 5'h00;
         cyc(4);
         rd_chk(`TPW_OFF_COUNTER, (e == 1) ? 16'h0004 : 16'h0001);
      end
      wr(`TPW_OFF_CTRL2, 16'h0002);
      @(posedge ref_clk_i);
      fire <= 5'h10;
      @(posedge ref_clk_i);
      fire <= 5'h00;
      // Lands the write on the edge where the count sits at the period value
      cyc(19);
      wr(`TPW_OFF_COUNTER, 16'h0055);
      rd_chk(`TPW_OFF_COUNTER, 16'h0001);
      wr(`TPW_OFF_MODE, 16'h0000);
   endtask

   // Main sequence
   initial
   begin
      mismatches = 0;
      check_count = 0;
      bus = '0;
      fire = 5'h00;
      rst_b_i = 1'b0;
      repeat (12) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      t_reset;
      t_pwm;
      t_stop;
      t_irq;
      t_cap;
      t_src;
      t_trig;
      summarize;
   end
endmodule // tpw_timer_tb_top
`default_nettype wire
